// ### core/ddl_dual_latch.sv
// What this block does
// - Mode high gives two independent channels
// - Each channel takes its own 14-bit word
// - Unsigned binary, highest bit most significant
// - All ones drives primary output full scale
// - Input latch then converter latch per channel
// - Strobe loads input, clock loads converter
// - Mode low selects shared interleaved port
// - Interleaved mode repurposes channel pins
// - Shared word captured on shared strobe rise
// - Select high to channel 1, low channel 2
// - Resync high blocks converter updates
// - First clock after resync loads both
// - Then update on every other clock edge
// - Sleep turns current off, slow recovery
//
// Holds the top module: strobe/clock sampling, latches, buffer, sleep.
// Assumes all pins are synchronous to clk and edges are one clk apart.
`timescale 1ns/1ps
`include "ddl_params.svh"
module ddl_dual_latch
#(
    parameter int DATA_W = `DDL_DATA_W,
    parameter int WAKE_CYC = `DDL_WAKE_CYC,
    parameter int BUF_DEPTH = `DDL_BUF_DEPTH
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mode_dual,
    input wire logic [DATA_W-1:0] channel1_data,
    input wire logic [DATA_W-1:0] channel2_data,
    input wire logic channel1_write_strobe,
    input wire logic channel2_write_strobe,
    input wire logic channel1_update_clock,
    input wire logic channel2_update_clock,
    input wire logic sleep,
    input wire logic conv_ready,
    output logic conv_valid,
    output logic [DATA_W-1:0] conv1_code,
    output logic [DATA_W-1:0] conv2_code,
    output logic [DATA_W-1:0] conv1_code_comp,
    output logic [DATA_W-1:0] conv2_code_comp,
    output logic output_enable,
    output logic word_dropped
);
    // ********************************************
    // Reset release
    // ********************************************
    logic rst_a_r;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_a_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a_r <= 1'b1;
            rst_n <= rst_a_r;
        end
    end

    // ********************************************
    // Pin roles
    // ********************************************
    // Interleaved pins reuse the channel pins, so decode is by name only.
    wire is_dual = (mode_dual == 1'b1);
    wire shared_write_strobe = channel1_write_strobe;
    wire shared_update_clock = channel1_update_clock;
    wire channel_select = channel2_write_strobe;
    wire interleave_resync = channel2_update_clock;
    wire wr1_rise;
    wire wr2_rise;
    wire ck1_rise;
    wire ck2_rise;
    // Detectors reset to low, so pins must idle low at reset release
    ddl_edge_det u_wr1
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(channel1_write_strobe),
        .rise(wr1_rise)
    );
    ddl_edge_det u_wr2
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(channel2_write_strobe),
        .rise(wr2_rise)
    );
    ddl_edge_det u_ck1
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(channel1_update_clock),
        .rise(ck1_rise)
    );
    ddl_edge_det u_ck2
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(channel2_update_clock),
        .rise(ck2_rise)
    );

    // ********************************************
    // Channel input latches
    // ********************************************
    logic [DATA_W-1:0] in1_r;
    logic [DATA_W-1:0] in2_r;
    wire shared_rise = ~is_dual & wr1_rise;
    wire ld_in1 = is_dual ? wr1_rise : (shared_rise & channel_select);
    wire ld_in2 = is_dual ? wr2_rise : (shared_rise & ~channel_select);
    // Shared port uses channel 1 data pins as the common word.
    wire [DATA_W-1:0] d2_src = is_dual ? channel2_data : channel1_data;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in1_r <= `DDL_CODE_ZERO;
            in2_r <= `DDL_CODE_ZERO;
        end
        else
        begin
            if (ld_in1)
                in1_r <= channel1_data;
            if (ld_in2)
                in2_r <= d2_src;
        end
    end

    // ********************************************
    // Interleaved divide-by-two
    // ********************************************
    ddl_pkg::ddl_phase_type ph_r;
    ddl_pkg::ddl_phase_type ph_nxt;
    wire iq_edge = ~is_dual & ~interleave_resync & ck1_rise;
    wire iq_fire = iq_edge & (ph_r == ddl_pkg::DDL_PH_SYNC);
    always_comb
    begin
        ph_nxt = ph_r;
        if (is_dual | interleave_resync)
            ph_nxt = ddl_pkg::DDL_PH_SYNC;
        else if (iq_edge)
            ph_nxt = (ph_r == ddl_pkg::DDL_PH_SYNC) ?
                ddl_pkg::DDL_PH_SKIP : ddl_pkg::DDL_PH_SYNC;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ph_r <= ddl_pkg::DDL_PH_SYNC;
        else
            ph_r <= ph_nxt;
    end

    // ********************************************
    // Converter update requests through the buffer
    // ********************************************
    // Each request carries both input latches and which lanes to load.
    localparam int BW = 2 * DATA_W + 2;
    wire upd1 = is_dual ? ck1_rise : iq_fire;
    wire upd2 = is_dual ? ck2_rise : iq_fire;
    ddl_word_if #(.W(BW)) req_w ();
    ddl_word_if #(.W(BW)) cnv_w ();
    assign req_w.valid = upd1 | upd2;
    assign req_w.data = {upd1, upd2, in1_r, in2_r};
    ddl_skid_buf #(.W(BW), .DEPTH(BUF_DEPTH)) u_buf
    (
        .clk(clk),
        .rst_n(rst_n),
        .in_w(req_w),
        .out_w(cnv_w)
    );
    // Update edges are not throttleable; an edge hitting a full buffer
    // is flagged rather than silently merged.
    wire drop = req_w.valid & ~req_w.ready;

    // ********************************************
    // Converter latches and sleep
    // ********************************************
    logic [DATA_W-1:0] cv1_r;
    logic [DATA_W-1:0] cv2_r;
    logic [DATA_W-1:0] cp1_r;
    logic [DATA_W-1:0] cp2_r;
    logic valid_r;
    logic drop_r;
    logic oe_r;
    logic taken;
    assign taken = ~valid_r | conv_ready;
    assign cnv_w.ready = taken;
    wire [BW-1:0] q = cnv_w.data;
    wire pop = cnv_w.valid & taken;
    wire ld_cv1 = pop & q[BW-1];
    wire ld_cv2 = pop & q[BW-2];
    // Complements are registered beside the codes so outputs are flops
    wire [DATA_W-1:0] cv1_nxt =
        ld_cv1 ? q[2*DATA_W-1:DATA_W] : cv1_r;
    wire [DATA_W-1:0] cv2_nxt =
        ld_cv2 ? q[DATA_W-1:0] : cv2_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            valid_r <= 1'b0;
        else if (taken)
            valid_r <= cnv_w.valid;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            drop_r <= 1'b0;
        else
            drop_r <= drop;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cv1_r <= `DDL_CODE_ZERO;
            cp1_r <= ~`DDL_CODE_ZERO;
        end
        else
        begin
            cv1_r <= cv1_nxt;
            cp1_r <= ~cv1_nxt;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cv2_r <= `DDL_CODE_ZERO;
            cp2_r <= ~`DDL_CODE_ZERO;
        end
        else
        begin
            cv2_r <= cv2_nxt;
            cp2_r <= ~cv2_nxt;
        end
    end

    ddl_pkg::ddl_pwr_type pwr_r;
    ddl_pkg::ddl_pwr_type pwr_nxt;
    logic [$clog2(WAKE_CYC+1)-1:0] wake_r;
    logic [$clog2(WAKE_CYC+1)-1:0] wake_nxt;
    always_comb
    begin
        pwr_nxt = pwr_r;
        wake_nxt = wake_r;
        unique case (pwr_r)
            ddl_pkg::DDL_PWR_ON:
                if (sleep)
                    pwr_nxt = ddl_pkg::DDL_PWR_OFF;
            ddl_pkg::DDL_PWR_OFF:
                if (!sleep)
                begin
                    pwr_nxt = ddl_pkg::DDL_PWR_WAKE;
                    wake_nxt = '0;
                end
            ddl_pkg::DDL_PWR_WAKE:
                if (sleep)
                    pwr_nxt = ddl_pkg::DDL_PWR_OFF;
                else if (wake_r == ($bits(wake_r))'(WAKE_CYC - 1))
                    pwr_nxt = ddl_pkg::DDL_PWR_ON;
                else
                    wake_nxt = wake_r + 1'b1;
            default:
                pwr_nxt = ddl_pkg::DDL_PWR_OFF;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_r <= ddl_pkg::DDL_PWR_ON;
            wake_r <= '0;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            wake_r <= wake_nxt;
        end
    end
    // Enable follows the next state so it flips with the power state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            oe_r <= 1'b1;
        else
            oe_r <= (pwr_nxt == ddl_pkg::DDL_PWR_ON);
    end

    // ********************************************
    // Outputs
    // ********************************************
    // Complement codes give the secondary output share, 16383 minus code.
    assign conv_valid = valid_r;
    assign conv1_code = cv1_r;
    assign conv2_code = cv2_r;
    assign conv1_code_comp = cp1_r;
    assign conv2_code_comp = cp2_r;
    assign output_enable = oe_r;
    assign word_dropped = drop_r;
endmodule : ddl_dual_latch

// ### core/ddl_params.svh
// Constants for the dual converter input latch block.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef DDL_PARAMS_SVH
`define DDL_PARAMS_SVH
`define DDL_DATA_W 14
`define DDL_CLK_PERIOD_NS 8
`define DDL_SLEEP_OFF_NS 50
`define DDL_SLEEP_OFF_CYC ((`DDL_SLEEP_OFF_NS) / (`DDL_CLK_PERIOD_NS))
`define DDL_WAKE_US 5
`define DDL_WAKE_CYC (((`DDL_WAKE_US) * 1000) / (`DDL_CLK_PERIOD_NS))
`define DDL_CODE_ZERO 14'h0000
`define DDL_BUF_DEPTH 2
`endif

// ### core/ddl_pkg.sv
// Types for the dual converter input latch block.
// Assumes the params header is compiled alongside.
package ddl_pkg;
    typedef enum logic {DDL_MODE_INTERLEAVED, DDL_MODE_DUAL} ddl_mode_type;
    typedef enum logic [1:0] {DDL_PWR_ON, DDL_PWR_OFF, DDL_PWR_WAKE}
        ddl_pwr_type;
    typedef enum logic {DDL_PH_SYNC, DDL_PH_SKIP} ddl_phase_type;
endpackage : ddl_pkg

// ### core/ddl_word_if.sv
// Valid/ready word carrier between the block's own modules.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface ddl_word_if #(parameter int W = 28);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : ddl_word_if

// ### core/ddl_edge_det.sv
// Rising edge detector for a strobe sampled on clk.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
module ddl_edge_det
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic rise
);
    logic prev_r;
    assign rise = level & ~prev_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= 1'b0;
        else
            prev_r <= level;
    end
endmodule : ddl_edge_det

// ### core/ddl_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; full refuses writes, empty offers nothing.
`timescale 1ns/1ps
module ddl_skid_buf
#(
    parameter int W = 28,
    parameter int DEPTH = 2
)
(
    input wire logic clk,
    input wire logic rst_n,
    ddl_word_if.dst in_w,
    ddl_word_if.src out_w
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    wire push = in_w.valid & in_w.ready;
    wire pop = out_w.valid & out_w.ready;
    assign in_w.ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_w.valid = (cnt_r != '0);
    assign out_w.data = mem_r[rd_r];
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_r] <= in_w.data;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ddl_skid_buf

// ### tb/ddl_src_model.sv
// Data source model driving strobes, update clocks and data words.
// Assumes the bench calls its tasks; pins move only at falling edges.
`timescale 1ns/1ps
module ddl_src_model
(
    input wire logic clk,
    output logic [13:0] d1, // Bit 13 is the most significant
    output logic [13:0] d2,
    output logic wr1,
    output logic wr2,
    output logic ck1,
    output logic ck2
);
    initial
    begin
        {d1, d2, wr1, wr2, ck1, ck2} = '0;
    end
    // ************************************************************
    // Pin tasks
    // ************************************************************
    // Data moves at the falling edge, clear of the sampling edge
    task automatic wr(input logic [1:0] m, input logic [13:0] a,
                      input logic [13:0] b);
        @(negedge clk);
        d1 = a;
        d2 = b;
        wr1 = m[0];
        wr2 = m[1];
        @(negedge clk);
        wr1 = 1'b0;
        wr2 = 1'b0;
        d1 = ~a; // Released bus shows the inverse, not the old word
        d2 = ~b;
    endtask : wr
    // Clock rises a full cycle after any strobe, at most every 2 clk
    task automatic tick(input logic [1:0] m);
        @(negedge clk);
        ck1 = ck1 | m[0];
        ck2 = ck2 | m[1];
        @(negedge clk);
        ck1 = ck1 & ~m[0];
        ck2 = ck2 & ~m[1];
    endtask : tick
    task automatic lvl2(input logic v);
        @(negedge clk);
        ck2 = v;
    endtask : lvl2
endmodule : ddl_src_model

// ### tb/ddl_dual_latch_chk.sv
// Port checker for the dual converter input latch.
// Assumes it is bound into ddl_dual_latch; wake count of 2 to 7.
`timescale 1ns/1ps
module ddl_dual_latch_chk
#(
    parameter int DATA_W = 14,
    parameter int WAKE_CYC = 4
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mode_dual,
    input wire logic channel1_update_clock,
    input wire logic channel2_update_clock,
    input wire logic sleep,
    input wire logic conv_ready,
    input wire logic conv_valid,
    input wire logic [DATA_W-1:0] conv1_code,
    input wire logic [DATA_W-1:0] conv2_code,
    input wire logic [DATA_W-1:0] conv1_code_comp,
    input wire logic [DATA_W-1:0] conv2_code_comp,
    input wire logic output_enable,
    input wire logic word_dropped
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    AST_COMP1: assert property (conv1_code_comp == ~conv1_code)
        else $error("ch1 complement wrong");
    AST_COMP2: assert property (conv2_code_comp == ~conv2_code)
        else $error("ch2 complement wrong");
    AST_STALL: assert property (conv_valid && !conv_ready |=>
        conv_valid && $stable(conv1_code) && $stable(conv2_code))
        else $error("codes moved during stall");
    AST_CHG: assert property ($changed(conv1_code) ||
        $changed(conv2_code) |-> conv_valid)
        else $error("code changed without valid");
    AST_DUAL: assert property (mode_dual &&
        $rose(channel1_update_clock) |-> ##[1:3] (conv_valid || word_dropped))
        else $error("dual update edge lost");
    AST_RESYNC: assert property (
        (!mode_dual && channel2_update_clock)[*3] |-> !$rose(conv_valid))
        else $error("update during resync");
    AST_DROP: assert property (word_dropped |->
        $past(conv_valid) && !$past(conv_ready))
        else $error("drop without stall");
    AST_SLEEP: assert property ($rose(sleep) ##1 sleep |=>
        !output_enable)
        else $error("sleep did not cut output");
    AST_WAKE: assert property ($fell(sleep) |=>
        !output_enable ##1 !output_enable)
        else $error("wake too fast");
    AST_ON: assert property ($fell(sleep) ##1 (!sleep)[*8] |->
        output_enable)
        else $error("wake too slow");
endmodule : ddl_dual_latch_chk
bind ddl_dual_latch ddl_dual_latch_chk #(.DATA_W(DATA_W),
    .WAKE_CYC(WAKE_CYC)) u_chk (.clk(clk), .reset_n(reset_n),
    .mode_dual(mode_dual), .channel1_update_clock(channel1_update_clock),
    .channel2_update_clock(channel2_update_clock), .sleep(sleep),
    .conv_ready(conv_ready), .conv_valid(conv_valid),
    .conv1_code(conv1_code), .conv2_code(conv2_code),
    .conv1_code_comp(conv1_code_comp), .conv2_code_comp(conv2_code_comp),
    .output_enable(output_enable), .word_dropped(word_dropped));

// ### tb/tb.sv
// Self-checking bench for the dual converter input latch.
// Assumes the source model drives data, strobe and clock pins; wake count shortened to 4.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin n_tests++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); n_fail++; end end
module tb;
    logic clk, reset_n, mode_dual, sleep, conv_ready, drop_seen;
    logic [13:0] ch1_d, ch2_d, c1, c2, c1n, c2n, last;
    logic wr1, wr2, ck1, ck2, conv_valid, oe, dropped;
    int n_fail = 0;
    int n_tests = 0;
    ddl_src_model src (.clk(clk), .d1(ch1_d), .d2(ch2_d), .wr1(wr1),
        .wr2(wr2), .ck1(ck1), .ck2(ck2));
    ddl_dual_latch #(.WAKE_CYC(4)) dut (.clk(clk), .reset_n(reset_n),
        .mode_dual(mode_dual), .channel1_data(ch1_d), .channel2_data(ch2_d),
        .channel1_write_strobe(wr1), .channel2_write_strobe(wr2),
        .channel1_update_clock(ck1), .channel2_update_clock(ck2),
        .sleep(sleep), .conv_ready(conv_ready), .conv_valid(conv_valid),
        .conv1_code(c1), .conv2_code(c2), .conv1_code_comp(c1n),
        .conv2_code_comp(c2n), .output_enable(oe), .word_dropped(dropped));
    always @(posedge clk)
        if (dropped === 1'b1) drop_seen <= 1'b1;
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask : settle
    task automatic t_dual();
        src.wr(2'b11, 14'h3FFF, 14'h0001);
        settle();
        `CHK("conv1", 14'h0000, c1)
        src.tick(2'b01);
        settle();
        `CHK("conv1", 14'h3FFF, c1)
        `CHK("conv2", 14'h0000, c2)
        `CHK("comp1", 14'h0000, c1n)
        src.tick(2'b10);
        settle();
        `CHK("conv2", 14'h0001, c2)
        `CHK("conv1", 14'h3FFF, c1)
        `CHK("comp2", 14'h3FFE, c2n)
        $display("dual port test done");
    endtask : t_dual
    task automatic t_ilv();
        mode_dual = 1'b0;
        src.lvl2(1'b1);
        src.wr(2'b11, 14'h0AAA, 14'h2222);
        src.wr(2'b01, 14'h1555, 14'h2222);
        src.tick(2'b01);
        settle();
        `CHK("conv1", 14'h3FFF, c1)
        src.lvl2(1'b0);
        src.tick(2'b01);
        settle();
        `CHK("conv1", 14'h0AAA, c1)
        `CHK("conv2", 14'h1555, c2)
        src.wr(2'b11, 14'h0123, 14'h2222);
        src.wr(2'b01, 14'h0321, 14'h2222);
        src.tick(2'b01);
        settle();
        `CHK("conv1", 14'h0AAA, c1)
        src.tick(2'b01);
        settle();
        `CHK("conv1", 14'h0123, c1)
        `CHK("conv2", 14'h0321, c2)
        $display("interleaved test done");
    endtask : t_ilv
    // Stall downstream until the buffer overflows, then drain it
    task automatic t_stall();
        mode_dual = 1'b1;
        conv_ready = 1'b0;
        drop_seen = 1'b0;
        for (int k = 1; k < 7 && drop_seen !== 1'b1; k++)
        begin
            src.wr(2'b01, 14'(k * 256), 14'h0000);
            src.tick(2'b01);
            settle();
            if (drop_seen !== 1'b1) last = 14'(k * 256);
        end
        `CHK("drop", 1'b1, drop_seen)
        `CHK("conv1", 14'h0100, c1)
        `CHK("valid", 1'b1, conv_valid)
        conv_ready = 1'b1;
        repeat (10) @(negedge clk);
        `CHK("conv1", last, c1)
        `CHK("valid", 1'b0, conv_valid)
        $display("stall test done");
    endtask : t_stall
    task automatic t_sleep();
        `CHK("oe", 1'b1, oe)
        sleep = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("oe", 1'b0, oe)
        sleep = 1'b0;
        @(negedge clk);
        `CHK("oe", 1'b0, oe)
        repeat (8) @(negedge clk);
        `CHK("oe", 1'b1, oe)
        $display("sleep test done");
    endtask : t_sleep
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run is about 100 cycles; the limit leaves wide margin
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial
    begin
        {reset_n, sleep, drop_seen, last} = '0;
        mode_dual = 1'b1;
        conv_ready = 1'b1;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        t_dual();
        t_ilv();
        t_stall();
        t_sleep();
        close_out();
    end
endmodule : tb
